// ==== ppfs_defines.svh ====
// register map, field positions, key values and reset values for the pin function select block
`ifndef PPFS_DEFINES_SVH
`define PPFS_DEFINES_SVH

`define PPFS_ADDR_W            32
`define PPFS_OFS_UNLOCK_FIRST  32'hFFFF0464
`define PPFS_OFS_PROT_CTRL     32'hFFFF0468
`define PPFS_OFS_UNLOCK_SECOND 32'hFFFF046C
`define PPFS_OFS_STATUS        32'hFFFF0470
`define PPFS_KEY_FIRST         8'h07
`define PPFS_KEY_SECOND        8'h13
`define PPFS_CTRL_RESET        8'h00
`define PPFS_BIT_ANALOG        0
`define PPFS_BIT_SERIAL        1
`define PPFS_CTRL_USED_MASK    8'h03

`endif

// ==== ppfs_pin_route.sv ====
// decodes the stored control value into the pin function of port 0 pins 0 to 3
`timescale 1ns/100ps
`include "ppfs_defines.svh"

module ppfs_pin_route (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // stored control value
   input  wire logic [7:0]          ctrl,
   // routing result
   output ppfs_pkg::ppfs_mode_t     mode,
   output logic                     analog_en,
   output logic                     spi_en,
   output logic                     i2c_en
);

   ppfs_pkg::ppfs_mode_t next_mode;

   // analog routing overrides the serial role
   always_comb begin
      if (ctrl[`PPFS_BIT_ANALOG]) begin
         next_mode = ppfs_pkg::PPFS_MODE_ANALOG;
      end else if (ctrl[`PPFS_BIT_SERIAL]) begin
         next_mode = ppfs_pkg::PPFS_MODE_I2C;
      end else begin
         next_mode = ppfs_pkg::PPFS_MODE_SPI;
      end
   end

   // registered so every pin select leaves a flip-flop
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode      <= ppfs_pkg::PPFS_MODE_SPI;
         analog_en <= 1'b0;
         spi_en    <= 1'b1;
         i2c_en    <= 1'b0;
      end else begin
         mode      <= next_mode;
         analog_en <= (next_mode == ppfs_pkg::PPFS_MODE_ANALOG);
         spi_en    <= (next_mode == ppfs_pkg::PPFS_MODE_SPI);
         i2c_en    <= (next_mode == ppfs_pkg::PPFS_MODE_I2C);
      end
   end

endmodule // ppfs_pin_route

// ==== ppfs_pkg.sv ====
// types shared by the pin function select block
package ppfs_pkg;
   typedef enum logic [1:0] {
      PPFS_MODE_SPI,
      PPFS_MODE_I2C,
      PPFS_MODE_ANALOG
   } ppfs_mode_t;

   typedef enum logic [1:0] {
      PPFS_SEQ_IDLE,
      PPFS_SEQ_KEYED,
      PPFS_SEQ_HELD
   } ppfs_seq_t;
endpackage

// ==== ppfs_top.sv ====
// key protected function select register for port 0 pins 0 to 3
//
// Summary of operation
// - bit 1 picks SPI (0) or I2C (1)
// - bit 1 ignored by the decoded pin function while bit 0 set
// - bit 0 routes pins to analog inputs
// - control register resets to all zeros
`timescale 1ns/100ps
`include "ppfs_defines.svh"

module ppfs_top (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // register port
   input  wire logic [`PPFS_ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [31:0]               reg_rdata,
   // pin function selects
   output logic                           analog_input_select,
   output logic                           serial_role_select,
   output logic                           pin_spi_en,
   output logic                           pin_i2c_en,
   output logic                           pin_analog_en
);

   logic [7:0]           pin_func_protected_ctrl;
   logic [7:0]           held_value;
   logic                 seq_error;
   ppfs_pkg::ppfs_seq_t  seq;
   ppfs_pkg::ppfs_mode_t mode;

   logic wr_key1;
   logic wr_ctrl;
   logic wr_key2;
   logic commit;

   // address decode of the three keyed locations
   assign wr_key1 = reg_wr && (reg_addr == `PPFS_OFS_UNLOCK_FIRST)
                    && (reg_wdata[7:0] == `PPFS_KEY_FIRST);
   assign wr_ctrl = reg_wr && (reg_addr == `PPFS_OFS_PROT_CTRL);
   assign wr_key2 = reg_wr && (reg_addr == `PPFS_OFS_UNLOCK_SECOND)
                    && (reg_wdata[7:0] == `PPFS_KEY_SECOND);
   // commit only on a correct closing key while a value is held
   assign commit  = (seq == ppfs_pkg::PPFS_SEQ_HELD) && wr_key2;

   // sequence tracker: any other write in between breaks the chain,
   // reads do not since they cannot alter the pending value
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         seq <= ppfs_pkg::PPFS_SEQ_IDLE;
      end else if (reg_wr) begin
         unique case (seq)
            ppfs_pkg::PPFS_SEQ_IDLE: begin
               seq <= wr_key1 ? ppfs_pkg::PPFS_SEQ_KEYED : ppfs_pkg::PPFS_SEQ_IDLE;
            end
            ppfs_pkg::PPFS_SEQ_KEYED: begin
               if (wr_ctrl) begin
                  seq <= ppfs_pkg::PPFS_SEQ_HELD;
               end else begin
                  seq <= wr_key1 ? ppfs_pkg::PPFS_SEQ_KEYED : ppfs_pkg::PPFS_SEQ_IDLE;
               end
            end
            ppfs_pkg::PPFS_SEQ_HELD: begin
               seq <= wr_key1 ? ppfs_pkg::PPFS_SEQ_KEYED : ppfs_pkg::PPFS_SEQ_IDLE;
            end
         endcase
      end
   end

   // a fresh opening key while holding restarts rather than commits
   a_seq_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (seq == ppfs_pkg::PPFS_SEQ_HELD && wr_key1) |=> seq == ppfs_pkg::PPFS_SEQ_KEYED)
      else $error("opening key did not restart sequence");

   // pending value waits for the closing key
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         held_value <= `PPFS_CTRL_RESET;
      end else if (wr_ctrl && (seq == ppfs_pkg::PPFS_SEQ_KEYED)) begin
         held_value <= reg_wdata[7:0];
      end
   end

   // value is captured only right after a correct opening key
   a_held_only_keyed: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl && seq == ppfs_pkg::PPFS_SEQ_KEYED) |=> held_value == $past(reg_wdata[7:0]))
      else $error("keyed value not captured");

   // a closing key on its own must never commit a stale value
   a_key2_alone_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_key2 && seq != ppfs_pkg::PPFS_SEQ_HELD) |=> $stable(pin_func_protected_ctrl))
      else $error("lone closing key changed control");

   // only the used bits are stored, so stray upper bits cannot leak
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_func_protected_ctrl <= `PPFS_CTRL_RESET;
      end else if (commit) begin
         pin_func_protected_ctrl <= held_value & `PPFS_CTRL_USED_MASK;
      end
   end

   // sticky flag for a discarded control write, cleared by reading status
   // a set in the same cycle as the clearing read wins, so no error is lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         seq_error <= 1'b0;
      end else if (wr_ctrl && (seq != ppfs_pkg::PPFS_SEQ_KEYED)) begin
         seq_error <= 1'b1;
      end else if (reg_wr && (seq == ppfs_pkg::PPFS_SEQ_HELD) && !wr_key2) begin
         seq_error <= 1'b1;
      end else if (reg_rd && (reg_addr == `PPFS_OFS_STATUS)) begin
         seq_error <= 1'b0;
      end
   end

   // both ways of discarding a control value must raise the flag
   a_error_on_discard: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl && seq != ppfs_pkg::PPFS_SEQ_KEYED) |=> seq_error)
      else $error("discarded write not flagged");

   a_error_bad_close: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && seq == ppfs_pkg::PPFS_SEQ_HELD && !wr_key2) |=> seq_error)
      else $error("broken sequence not flagged");

   // with no write in the cycle nothing can set the flag again
   a_error_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `PPFS_OFS_STATUS && !reg_wr) |=> !seq_error)
      else $error("status read did not clear error");

   // read data in the cycle after the strobe; key registers read zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         if (reg_addr == `PPFS_OFS_PROT_CTRL) begin
            reg_rdata <= {24'h00_0000, pin_func_protected_ctrl};
         end else if (reg_addr == `PPFS_OFS_STATUS) begin
            reg_rdata <= {28'h000_0000, mode, (seq != ppfs_pkg::PPFS_SEQ_IDLE), seq_error};
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // readback mirrors the stored value; idle cycles must read zero
   a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `PPFS_OFS_PROT_CTRL)
      |=> reg_rdata == {24'h00_0000, $past(pin_func_protected_ctrl)})
      else $error("control readback wrong");

   a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero when idle");

   // raw bit copies for the pad ring
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         analog_input_select <= 1'b0;
         serial_role_select  <= 1'b0;
      end else begin
         analog_input_select <= pin_func_protected_ctrl[`PPFS_BIT_ANALOG];
         serial_role_select  <= pin_func_protected_ctrl[`PPFS_BIT_SERIAL];
      end
   end

   // pad copies trail the register by exactly one edge
   a_raw_copies: assert property (@(posedge sys_clk) disable iff (!rst_n)
      {serial_role_select, analog_input_select} == $past(pin_func_protected_ctrl[1:0]))
      else $error("pad copies do not follow control");

   // decoded pin function, one cycle behind the register
   ppfs_pin_route u_route (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .ctrl      (pin_func_protected_ctrl),
      .mode      (mode),
      .analog_en (pin_analog_en),
      .spi_en    (pin_spi_en),
      .i2c_en    (pin_i2c_en)
   );

   // checks
   a_pins_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $onehot({pin_spi_en, pin_i2c_en, pin_analog_en}))
      else $error("pin function not one-hot");

   a_reset_ctrl_zero: assert property (@(posedge sys_clk)
      $rose(rst_n) |-> pin_func_protected_ctrl == 8'h00)
      else $error("control not zero after reset");

   a_ctrl_needs_key: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !$past(commit) |-> $stable(pin_func_protected_ctrl))
      else $error("control changed without key sequence");

   a_full_sequence_commits: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_key1 && seq == ppfs_pkg::PPFS_SEQ_IDLE) ##1 (wr_ctrl && reg_wdata[7:0] == 8'h03)
      ##1 wr_key2 |=> pin_func_protected_ctrl == 8'h03)
      else $error("keyed write not stored");

   a_wrong_key_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (seq == ppfs_pkg::PPFS_SEQ_HELD && reg_wr && !wr_key2) |=> $stable(pin_func_protected_ctrl))
      else $error("bad closing key accepted");

   a_upper_bits_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pin_func_protected_ctrl[7:2] == 6'h00)
      else $error("reserved control bits set");

   a_analog_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pin_func_protected_ctrl[0] ##2 pin_func_protected_ctrl[0]
      |-> pin_analog_en && !pin_i2c_en && !pin_spi_en)
      else $error("serial role active in analog mode");

   a_i2c_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pin_func_protected_ctrl == 8'h02) [*2] |=> pin_i2c_en && !pin_spi_en)
      else $error("i2c role not applied");

   a_spi_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pin_func_protected_ctrl == 8'h00) [*2] |=> pin_spi_en && !pin_analog_en)
      else $error("digital spi role not applied");

endmodule // ppfs_top

// ==== ppfs_top_tb.sv ====
// self-checking bench for the key protected pin function select block
`timescale 1ns/100ps
`include "ppfs_defines.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module ppfs_top_tb;
   logic                    sys_clk;
   logic                    rst_n;
   logic [`PPFS_ADDR_W-1:0] reg_addr;
   logic [31:0]             reg_wdata;
   logic                    reg_wr;
   logic                    reg_rd;
   logic [31:0]             reg_rdata;
   logic                    analog_input_select;
   logic                    serial_role_select;
   logic                    pin_spi_en;
   logic                    pin_i2c_en;
   logic                    pin_analog_en;
   int                      failures;
   int                      n_checks;
   int                      cycles;
   logic [31:0]             seen;
   logic [7:0]              vals [5] = '{8'h02, 8'h03, 8'h01, 8'hFC, 8'hFE};
   logic [7:0]              bad1 [3] = '{8'h06, 8'h07, 8'h00};
   logic [7:0]              bad2 [3] = '{8'h13, 8'h12, 8'h00};

   ppfs_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .analog_input_select(analog_input_select), .serial_role_select(serial_role_select),
      .pin_spi_en(pin_spi_en), .pin_i2c_en(pin_i2c_en), .pin_analog_en(pin_analog_en));

   // 50 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // one write cycle; strobe stays up so writes can run back to back
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= {24'h000000, d};
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
   endtask

   // key, value, key as three consecutive writes
   task automatic seq(input logic [7:0] k1, input logic [7:0] v, input logic [7:0] k2);
      @(posedge sys_clk);
      wr(`PPFS_OFS_UNLOCK_FIRST, k1);
      wr(`PPFS_OFS_PROT_CTRL, v);
      wr(`PPFS_OFS_UNLOCK_SECOND, k2);
      reg_wr <= 1'b0;
   endtask

   // read data is only valid in the cycle after the strobe
   task automatic rd(input logic [31:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 seen = reg_rdata;
   endtask

   // pins follow the register one edge later
   task automatic pins(input logic [7:0] v);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("analog_sel", v[0], analog_input_select)
      `CHK("serial_sel", v[1], serial_role_select)
      `CHK("spi_en", ~v[0] & ~v[1], pin_spi_en)
      `CHK("i2c_en", ~v[0] & v[1], pin_i2c_en)
      `CHK("analog_en", v[0], pin_analog_en)
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // hang guard, well above the hundred or so cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         stop_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      pins(8'h00);
      rd(`PPFS_OFS_PROT_CTRL);
      `CHK("ctrl_reset", 32'h00000000, seen)
      rd(`PPFS_OFS_UNLOCK_FIRST);
      `CHK("key_read", 32'h00000000, seen)
      rd(32'hFFFF0474);
      `CHK("unmapped", 32'h00000000, seen)
      $display("test reset done");
      // keyed writes; upper bits never reach the register
      foreach (vals[i]) begin
         seq(`PPFS_KEY_FIRST, vals[i], `PPFS_KEY_SECOND);
         pins(vals[i] & `PPFS_CTRL_USED_MASK);
         rd(`PPFS_OFS_PROT_CTRL);
         `CHK("ctrl_keyed", {30'h0, vals[i][1:0]}, seen)
      end
      $display("test keyed done");
      // wrong first key, wrong second key, no keys at all; i2c from 0xFE must stay
      foreach (bad1[i]) begin
         seq(bad1[i], 8'h01, bad2[i]);
         pins(8'h02);
         rd(`PPFS_OFS_PROT_CTRL);
         `CHK("ctrl_kept", 32'h00000002, seen)
         rd(`PPFS_OFS_STATUS);
         `CHK("seq_error", 1'b1, seen[0])
         `CHK("status_mode", 2'h1, seen[3:2])
      end
      rd(`PPFS_OFS_STATUS);
      `CHK("error_clear", 1'b0, seen[0])
      $display("test refused done");
      // a read between the keyed writes leaves the sequence armed
      @(posedge sys_clk);
      wr(`PPFS_OFS_UNLOCK_FIRST, `PPFS_KEY_FIRST);
      reg_wr <= 1'b0;
      rd(`PPFS_OFS_STATUS);
      `CHK("in_progress", 1'b1, seen[1])
      @(posedge sys_clk);
      wr(`PPFS_OFS_PROT_CTRL, 8'h01);
      wr(`PPFS_OFS_UNLOCK_SECOND, `PPFS_KEY_SECOND);
      reg_wr <= 1'b0;
      pins(8'h01);
      rd(`PPFS_OFS_PROT_CTRL);
      `CHK("ctrl_interleaved", 32'h00000001, seen)
      $display("test interleave done");
      stop_test();
   end
endmodule // ppfs_top_tb
